// *** include/fsr_pkg.sv ***
// Constants shared by the status read-out block and its helpers.
// Assumes SPI mode 0 framing and status bytes of eight bits.

package fsr_pkg;

	// ****************************************
	// Read opcodes
	// ****************************************
	localparam logic [7:0] FSR_OP_READ_ONE = 8'h05;
	localparam logic [7:0] FSR_OP_READ_TWO = 8'h35;

	// ****************************************
	// Status byte one layout
	// ****************************************
	localparam int FSR_S1_LOCK_LOW = 7;
	localparam int FSR_S1_GUARD_LO = 2;
	localparam int FSR_S1_WLATCH   = 1;
	localparam int FSR_S1_BUSY     = 0;
	localparam logic [7:0] FSR_S1_WR_MASK = 8'hfc;

	// ****************************************
	// Status byte two layout
	// ****************************************
	localparam int FSR_S2_ERASE_PAUSE = 7;
	localparam int FSR_S2_INVERT      = 6;
	localparam int FSR_S2_PAGE_LO     = 3;
	localparam int FSR_S2_PROG_PAUSE  = 2;
	localparam int FSR_S2_FOUR_LANE   = 1;
	localparam int FSR_S2_LOCK_HIGH   = 0;
	localparam logic [7:0] FSR_S2_WR_MASK   = 8'h7b;
	localparam logic [7:0] FSR_S2_LOCK_MASK = 8'h38;

	// ****************************************
	// Reset values and counters
	// ****************************************
	localparam logic [7:0] FSR_S1_RESET = 8'h00;
	localparam logic [7:0] FSR_S2_RESET = 8'h00;
	localparam logic [2:0] FSR_BIT_FIRST = 3'h7;
	localparam logic [2:0] FSR_BIT_ZERO  = 3'h0;
	localparam logic [1:0] FSR_PAGE_NONE = 2'h0;
	localparam int FSR_SYNC_STAGES = 2;

	// Link state, one-hot
	typedef enum logic [2:0] {
		FSR_ST_OPCODE = 3'b001,
		FSR_ST_SEND   = 3'b010,
		FSR_ST_SKIP   = 3'b100
	} fsr_state_t;

endpackage

// *** hdl/fsr_sync.sv ***
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to core_clk; only stage two is read.
`timescale 1ns/1ps
`default_nettype none

module fsr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic [WIDTH-1:0] rst_val,
	output logic      [WIDTH-1:0] sync_out
);

	import fsr_pkg::*;

	// Chain counts as filled once every stage has taken a pin sample
	localparam logic [1:0] FILL_DONE = 2'(FSR_SYNC_STAGES);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	// ****************************************
	// Stage logic
	// ****************************************
	// First stage feeds nothing but the second
	always_comb begin
		meta_nxt = pin_in;
		sync_nxt = meta_r;
	end

	// Reset to all zeros is not wanted for every bit, so the caller
	// picks idle levels; only constants are loaded under reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	// Idle level substituted until the chain has filled once
	logic [1:0] fill_r;
	logic [1:0] fill_nxt;
	always_comb begin
		fill_nxt = fill_r;
		if (fill_r != FILL_DONE) begin
			fill_nxt = fill_r + 2'h1;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fill_r <= 2'h0;
		end else begin
			fill_r <= fill_nxt;
		end
	end

	assign sync_out = (fill_r == FILL_DONE) ? sync_r : rst_val;

endmodule
`default_nettype wire

// *** hdl/fsr_status_read.sv ***
// Status byte read-out for a serial flash: holds both status bytes and
// streams either one on the serial output while chip select stays low.
// Assumes SPI mode 0 pins that are sampled by core_clk, serial clock
// well below a quarter of core_clk, and status inputs on core_clk.
`timescale 1ns/1ps
`default_nettype none

module fsr_status_read (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Serial link pins
	input  wire logic       spi_clk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_si,
	output logic            spi_so_o,
	output logic            spi_so_oe,
	// Live hardware status
	input  wire logic       busy_in,
	input  wire logic       erase_paused_in,
	input  wire logic       program_paused_in,
	// Write latch control
	input  wire logic       wlatch_set,
	input  wire logic       op_end,
	// Status write from the write command logic
	input  wire logic       stat_wr_valid,
	input  wire logic [7:0] stat_wr_one,
	input  wire logic [7:0] stat_wr_two,
	// Security page change gate
	input  wire logic       page_change_req,
	input  wire logic [1:0] page_change_sel,
	output logic            page_change_go,
	// Current fields
	output logic            protect_lock_low,
	output logic            protect_lock_high,
	output logic [4:0]      block_guard,
	output logic            guard_invert,
	output logic [2:0]      page_lock,
	output logic            four_lane_enable,
	output logic            write_latch_flag
);

	import fsr_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] pins_s;
	logic       sclk_s;
	logic       cs_n_s;
	logic       si_s;

	// Clock, select and data share one chain, so the sampled data bit
	// lines up with the detected clock edge; the serial clock must stay
	// below a quarter of core_clk for every phase to be seen
	// Idle levels: clock low, select high, data low
	fsr_sync #(
		.WIDTH (3)
	) u_pins (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   ({spi_clk, spi_cs_n, spi_si}),
		.rst_val  (3'h2),
		.sync_out (pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign si_s   = pins_s[0];

	// ****************************************
	// Serial clock edges
	// ****************************************
	logic sclk_d_r;
	logic sclk_d_nxt;
	logic sclk_rise;
	logic sclk_fall;

	// Delayed copy starts at the idle low level of the pin, so the
	// release of reset never reads as a rising edge
	always_comb begin
		sclk_d_nxt = sclk_s;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
		end
	end

	// Edges only count inside a frame,
	// so a clock that idles while select is high is never acted on
	assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

	// ****************************************
	// Status storage
	// ****************************************
	logic [7:0] stat_one_r;
	logic [7:0] stat_one_nxt;
	logic [7:0] stat_two_r;
	logic [7:0] stat_two_nxt;
	logic       wlatch_r;
	logic       wlatch_nxt;
	logic       go_r;
	logic       go_nxt;
	logic [2:0] sel_lock;

	always_comb begin
		stat_one_nxt = stat_one_r;
		stat_two_nxt = stat_two_r;
		wlatch_nxt   = wlatch_r;
		go_nxt       = 1'b0;
		// No protection-lock or write-pin gating here: the write command
		// logic decides whether a status write may happen at all
		// masked status write
		if (stat_wr_valid) begin
			stat_one_nxt = (stat_one_r & ~FSR_S1_WR_MASK)
				| (stat_wr_one & FSR_S1_WR_MASK);
			stat_two_nxt = (stat_two_r & ~FSR_S2_WR_MASK)
				| (stat_wr_two & FSR_S2_WR_MASK);
			stat_two_nxt = stat_two_nxt
				| (stat_two_r & FSR_S2_LOCK_MASK);
		end
		if (op_end) begin
			wlatch_nxt = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (wlatch_set) begin
			wlatch_nxt = 1'b1;
		end
		// Selector zero names no page and never opens the gate
		// locked page refused
		if (page_change_req && page_change_sel != FSR_PAGE_NONE) begin
			go_nxt = ~sel_lock[page_change_sel - 2'h1];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_one_r <= FSR_S1_RESET;
			stat_two_r <= FSR_S2_RESET;
			wlatch_r   <= 1'b0;
			go_r       <= 1'b0;
		end else begin
			stat_one_r <= stat_one_nxt;
			stat_two_r <= stat_two_nxt;
			wlatch_r   <= wlatch_nxt;
			go_r       <= go_nxt;
		end
	end

	// Lock bits in page order: bit 0 guards page one
	assign sel_lock = stat_two_r[FSR_S2_PAGE_LO +: 3];

	// ****************************************
	// Live status bytes
	// ****************************************
	logic [7:0] live_one;
	logic [7:0] live_two;

	// Writable bits and the write latch come from storage, busy and pause bits from hardware
	// Busy and pause bits are never stored, so they are always live
	always_comb begin
		live_one = stat_one_r & FSR_S1_WR_MASK;
		live_one[FSR_S1_WLATCH] = wlatch_r;
		live_one[FSR_S1_BUSY] = busy_in;
		live_two = stat_two_r & FSR_S2_WR_MASK;
		live_two[FSR_S2_ERASE_PAUSE] = erase_paused_in;
		live_two[FSR_S2_PROG_PAUSE] = program_paused_in;
	end

	// ****************************************
	// Link sequencer
	// ****************************************
	fsr_state_t state_r;
	fsr_state_t state_nxt;
	logic [7:0] op_r;
	logic [7:0] op_nxt;
	logic [2:0] op_cnt_r;
	logic [2:0] op_cnt_nxt;
	logic       sel_two_r;
	logic       sel_two_nxt;
	logic [2:0] bit_r;
	logic [2:0] bit_nxt;
	logic [7:0] snap_r;
	logic [7:0] snap_nxt;
	logic       so_r;
	logic       so_nxt;
	logic       oe_r;
	logic       oe_nxt;
	logic [7:0] op_full;
	logic [7:0] live_sel;

	// Opcode arrives MSB first, so each new bit enters at the bottom
	assign op_full  = {op_r[6:0], si_s};
	assign live_sel = sel_two_r ? live_two : live_one;

	always_comb begin
		state_nxt   = state_r;
		op_nxt      = op_r;
		op_cnt_nxt  = op_cnt_r;
		sel_two_nxt = sel_two_r;
		bit_nxt     = bit_r;
		snap_nxt    = snap_r;
		so_nxt      = so_r;
		oe_nxt      = oe_r;
		if (cs_n_s) begin
			// any bit, no side effect
			// Stored status is never touched from here, so a cut byte is harmless
			state_nxt  = FSR_ST_OPCODE;
			op_cnt_nxt = FSR_BIT_ZERO;
			bit_nxt    = FSR_BIT_FIRST;
			oe_nxt     = 1'b0;
		end else begin
			unique case (state_r)
				FSR_ST_OPCODE: begin
					if (sclk_rise) begin
						op_nxt     = op_full;
						op_cnt_nxt = op_cnt_r + 3'h1;
						if (op_cnt_r == FSR_BIT_FIRST) begin
							if (op_full == FSR_OP_READ_ONE) begin
								state_nxt   = FSR_ST_SEND;
								sel_two_nxt = 1'b0;
							end else if (op_full == FSR_OP_READ_TWO) begin
								state_nxt   = FSR_ST_SEND;
								sel_two_nxt = 1'b1;
							end else begin
								state_nxt = FSR_ST_SKIP;
							end
						end
					end
				end
				FSR_ST_SEND: begin
					if (sclk_fall) begin
						oe_nxt  = 1'b1;
						bit_nxt = bit_r - 3'h1;
						if (bit_r == FSR_BIT_FIRST) begin
							// Snapshot at bit 7 keeps one repetition self-consistent;
							// a status change in mid-byte shows in the next one
							// fresh copy per byte
							snap_nxt = live_sel;
							so_nxt   = live_sel[FSR_BIT_FIRST];
						end else begin
							so_nxt = snap_r[bit_r];
						end
					end
				end
				FSR_ST_SKIP: begin
					// Other opcodes belong to other blocks
					// Stays silent until select rises, then the opcode count restarts
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers; select, not reset, ends every frame
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r   <= FSR_ST_OPCODE;
			op_r      <= 8'h00;
			op_cnt_r  <= FSR_BIT_ZERO;
			sel_two_r <= 1'b0;
			bit_r     <= FSR_BIT_FIRST;
			snap_r    <= 8'h00;
			so_r      <= 1'b0;
			oe_r      <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			op_r      <= op_nxt;
			op_cnt_r  <= op_cnt_nxt;
			sel_two_r <= sel_two_nxt;
			bit_r     <= bit_nxt;
			snap_r    <= snap_nxt;
			so_r      <= so_nxt;
			oe_r      <= oe_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Fields come straight from storage: the rest of the device sees
	// a status write one cycle after it is taken
	assign spi_so_o          = so_r;
	assign spi_so_oe         = oe_r;
	assign page_change_go    = go_r;
	assign protect_lock_low  = stat_one_r[FSR_S1_LOCK_LOW];
	assign block_guard       = stat_one_r[FSR_S1_GUARD_LO +: 5];
	assign protect_lock_high = stat_two_r[FSR_S2_LOCK_HIGH];
	assign guard_invert      = stat_two_r[FSR_S2_INVERT];
	assign page_lock         = sel_lock;
	assign four_lane_enable  = stat_two_r[FSR_S2_FOUR_LANE];
	assign write_latch_flag  = wlatch_r;

endmodule
`default_nettype wire

// *** tb/fsr_status_read_monitor.sv ***
// Pin and field checks for the status read-out block.
// Assumes it is bound into fsr_status_read; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module fsr_status_read_monitor (
	input	wire logic		core_clk,
	input	wire logic		sys_rst,
	input	wire logic		spi_clk,
	input	wire logic		spi_cs_n,
	input	wire logic		spi_so_o,
	input	wire logic		spi_so_oe,
	input	wire logic		wlatch_set,
	input	wire logic		op_end,
	input	wire logic		stat_wr_valid,
	input	wire logic [7:0]	stat_wr_one,
	input	wire logic [7:0]	stat_wr_two,
	input	wire logic		page_change_req,
	input	wire logic [1:0]	page_change_sel,
	input	wire logic		page_change_go,
	input	wire logic		protect_lock_low,
	input	wire logic		protect_lock_high,
	input	wire logic [4:0]	block_guard,
	input	wire logic		guard_invert,
	input	wire logic [2:0]	page_lock,
	input	wire logic		four_lane_enable,
	input	wire logic		write_latch_flag
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Select high longer than the sync delay must leave the pin released
	oe_off_idle_a: assert property (spi_cs_n [*6] |-> !spi_so_oe)
		else $error("output driven while select high");
	// Data may only move while the serial clock is low, after a fall
	so_on_fall_a: assert property (spi_so_oe && $changed(spi_so_o) |-> !spi_clk)
		else $error("output changed with serial clock high");
	latch_set_a: assert property (wlatch_set |=> write_latch_flag)
		else $error("write latch not set");
	latch_clear_a: assert property (op_end && !wlatch_set |=> !write_latch_flag)
		else $error("write latch not cleared");
	guard_write_a: assert property (stat_wr_valid |=>
		{protect_lock_low, block_guard} == $past(stat_wr_one[7:2]))
		else $error("byte one writable bits wrong");
	byte_two_wr_a: assert property (stat_wr_valid |=>
		{guard_invert, four_lane_enable, protect_lock_high} ==
		{$past(stat_wr_two[6]), $past(stat_wr_two[1:0])})
		else $error("byte two writable bits wrong");
	// Page lock bits are one-way: only reset returns a set bit to zero
	page_sticky_a: assert property (1'b1 |=> (page_lock & $past(page_lock)) == $past(page_lock))
		else $error("page lock cleared");
	page_gate_a: assert property (page_change_req && page_change_sel != 2'h0 |=>
		page_change_go == !$past(page_lock[page_change_sel - 2'h1]))
		else $error("page gate answer wrong");
endmodule

bind fsr_status_read fsr_status_read_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe),
	.wlatch_set(wlatch_set), .op_end(op_end), .stat_wr_valid(stat_wr_valid),
	.stat_wr_one(stat_wr_one), .stat_wr_two(stat_wr_two), .page_change_req(page_change_req),
	.page_change_sel(page_change_sel), .page_change_go(page_change_go),
	.protect_lock_low(protect_lock_low), .protect_lock_high(protect_lock_high),
	.block_guard(block_guard), .guard_invert(guard_invert), .page_lock(page_lock),
	.four_lane_enable(four_lane_enable), .write_latch_flag(write_latch_flag));
`default_nettype wire

// *** tb/fsr_spi_host.sv ***
// SPI mode 0 host model with a 125 ns serial clock.
// Assumes the device answers on spi_so_o qualified by spi_so_oe.
`timescale 1ns/1ps
`default_nettype none

module fsr_spi_host (
	input	wire logic	spi_so_o,
	input	wire logic	spi_so_oe,
	output	logic		spi_clk,
	output	logic		spi_cs_n,
	output	logic		spi_si
);
	// Clock stands low between frames
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	// Opcode MSB first, then n bits taken on rising edges
	task automatic frame(input logic [7:0] op, input int n, output logic [15:0] rx,
		output int on);
		rx = 16'h0;
		on = 0;
		// Step off the core clock edge on which the caller returns
		#2;
		// select low for the whole frame
		spi_cs_n = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			#31;
			spi_si = (i < 8) ? op[7 - i] : ~spi_si;
			#31.5;
			spi_clk = 1'b1;
			// A released line reads as the inverse of its last level
			rx = (i < 8) ? rx : {rx[14:0], spi_so_oe ? spi_so_o : ~spi_so_o};
			on += (i >= 8) && spi_so_oe;
			#62.5;
			spi_clk = 1'b0;
		end
		#62.5;
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#100;
	endtask
endmodule
`default_nettype wire

// *** tb/fsr_status_read_tb.sv ***
// Self-checking bench for the status read-out block.
// Assumes the host model drives the link pins.
`timescale 1ns/1ps
`default_nettype none

module fsr_status_read_tb;
	import fsr_pkg::*;
	logic core_clk, sys_rst, busy_in, erase_paused_in, program_paused_in, wl;
	logic wlatch_set, op_end, stat_wr_valid, page_change_req, page_change_go;
	logic spi_clk, spi_cs_n, spi_si, spi_so_o, spi_so_oe, write_latch_flag;
	logic protect_lock_low, protect_lock_high, guard_invert, four_lane_enable;
	logic [7:0] stat_wr_one, stat_wr_two, m1, m2, lfsr_r, op, eo;
	logic [4:0] block_guard;
	logic [2:0] page_lock, lv;
	logic [1:0] page_change_sel;
	logic [15:0] rx;
	int on, comparisons, fail_count, cycles, k;

	fsr_status_read DUT (.core_clk(core_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe),
		.busy_in(busy_in), .erase_paused_in(erase_paused_in),
		.program_paused_in(program_paused_in), .wlatch_set(wlatch_set), .op_end(op_end),
		.stat_wr_valid(stat_wr_valid), .stat_wr_one(stat_wr_one), .stat_wr_two(stat_wr_two),
		.page_change_req(page_change_req), .page_change_sel(page_change_sel),
		.page_change_go(page_change_go), .protect_lock_low(protect_lock_low),
		.protect_lock_high(protect_lock_high), .block_guard(block_guard),
		.guard_invert(guard_invert), .page_lock(page_lock),
		.four_lane_enable(four_lane_enable), .write_latch_flag(write_latch_flag));
	fsr_spi_host host (.spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Expected byte from the bench model; v is busy, erase and program pause
	function automatic logic [7:0] expb(input logic s, input logic [2:0] v);
		if (s) return m2 | {v[1], 4'h0, v[0], 2'h0};
		return m1 | {6'h0, wl, v[2]};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Page locks can only be added by a write, never removed by one
	task automatic wr(input logic [7:0] a, input logic [7:0] b);
		@(posedge core_clk);
		{stat_wr_valid, stat_wr_one, stat_wr_two} <= {1'b1, a, b};
		@(posedge core_clk);
		stat_wr_valid <= 1'b0;
		m1 = a & 8'hfc;
		m2 = (b & 8'h7b) | (m2 & 8'h38);
		#1;
		chk({protect_lock_low, block_guard, 3'h0, guard_invert, page_lock, 1'b0,
			four_lane_enable, protect_lock_high}, {m1, m2});
	endtask
	task automatic gate;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			{page_change_req, page_change_sel} <= {1'b1, 2'(i)};
			@(posedge core_clk);
			page_change_req <= 1'b0;
			#1;
			chk(16'(page_change_go), 16'((i != 0) && !m2[i + 2]));
		end
	endtask
	task automatic pulse(input logic [1:0] v);
		@(posedge core_clk);
		{wlatch_set, op_end} <= v;
		@(posedge core_clk);
		{wlatch_set, op_end} <= 2'h0;
		wl = v[1] | (wl & !v[0]);
		#1;
		chk(16'(write_latch_flag), 16'(wl));
	endtask
	task automatic live(input logic [2:0] v);
		@(posedge core_clk);
		{busy_in, erase_paused_in, program_paused_in} <= v;
		lv = v;
	endtask

	// Cuts a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		{busy_in, erase_paused_in, program_paused_in, wlatch_set, op_end, lv} = '0;
		{stat_wr_valid, page_change_req, page_change_sel, stat_wr_one, stat_wr_two} = '0;
		{m1, m2, wl} = '0;
		lfsr_r = 8'h1b;
		sys_rst = 1'b1;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		chk({2'h0, protect_lock_low, block_guard, guard_invert, page_lock, four_lane_enable,
			protect_lock_high, write_latch_flag, spi_so_oe}, 16'h0);
		gate();
		for (k = 0; k < 6; k++) begin
			lfsr_r = lfsr_next(lfsr_r);
			op = lfsr_r;
			lfsr_r = lfsr_next(lfsr_r);
			wr(op, lfsr_r);
		end
		wr(8'hff, 8'hff);
		wr(8'h00, 8'h00);
		gate();
		pulse(2'b10);
		pulse(2'b11);
		pulse(2'b01);
		pulse(2'b10);
		$display("test fields done");
		// Live inputs flip mid-frame, so the two repetitions must differ
		for (k = 0; k < 6; k++) begin
			lfsr_r = lfsr_next(lfsr_r);
			live(lfsr_r[2:0]);
			eo = expb(k[0], lv);
			fork
				host.frame(k[0] ? 8'h35 : 8'h05, 16, rx, on);
				begin #1500; live(~lv); end
			join
			chk(rx, {eo, expb(k[0], lv)});
			chk(16'(on), 16'd16);
		end
		host.frame(lfsr_r | 8'h80, 8, rx, on);
		chk(16'(on), 16'h0);
		host.frame(8'h05, 3, rx, on);
		chk(rx, 16'(expb(1'b0, lv) >> 5));
		chk(16'(spi_so_oe), 16'h0);
		$display("test stream done");
		// A second reset mid-run must drop the latch that is set above
		@(posedge core_clk);
		sys_rst <= 1'b1;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		{m1, m2, wl} = '0;
		repeat (6) @(posedge core_clk);
		#1;
		chk({2'h0, protect_lock_low, block_guard, guard_invert, page_lock, four_lane_enable,
			protect_lock_high, write_latch_flag, spi_so_oe}, 16'h0);
		$display("test reset done");
		summarize();
	end
endmodule
`default_nettype wire
